// ### esft_pkg.sv
package esft_pkg;
  // ********************************
  // Register map and fields
  // ********************************
  localparam logic [7:0] ADDR_TRIG = 8'h0A;
  localparam logic [7:0] ADDR_OPERATING_STATE = 8'h0B;
  localparam logic [7:0] ADDR_INTSRC = 8'h0C;
  localparam int TRIG_LSB = 2;
  localparam logic [3:0] TRIG_RESET = 4'h0;
  localparam int GERR_BIT = 7;
  localparam int AGE_LSB = 2;
  localparam int SLEEP_WAKE_EVENT_BIT = 7;
  localparam int FIFO_EVENT_BIT = 6;
  localparam int SRC_FUNC_LSB = 2;
  localparam int SAMPLE_READY_EVENT_BIT = 0;
  localparam logic [4:0] AGE_MAX = 5'h1F;
  localparam logic [1:0] OPS_STANDBY = 2'h0;
  localparam logic [1:0] OPS_WAKE = 2'h1;
  localparam logic [1:0] OPS_SLEEP = 2'h2;
  // ********************************
  // FIFO figures
  // ********************************
  localparam logic [1:0] FMODE_TRIGGER = 2'h3;
  localparam logic [6:0] FIFO_DEPTH = 7'h20;
  localparam logic [5:0] FIFO_FULL = 6'h20;
  localparam logic [5:0] FIFO_EMPTY = 6'h00;
  localparam logic [5:0] WMRK_OFF = 6'h00;

  typedef enum logic [2:0] {
    ESFT_STANDBY = 3'b001,
    ESFT_WAKE = 3'b010,
    ESFT_SLEEP = 3'b100
  } esft_state_t;

  // Order: transient, orientation, tap, fall/motion (bit 3 down to 0)
  typedef struct packed {
    logic trans;
    logic orient;
    logic tap;
    logic fall;
  } esft_func_t;

  typedef struct packed {
    logic fifo;
    logic trans;
    logic orient;
    logic tap;
    logic fall;
  } esft_srcrd_t;
endpackage

// ### esft_sticky.sv
`timescale 1ns/1ps
module esft_sticky #(
  parameter int N = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [N-1:0] lvl,
  input wire logic [N-1:0] clr,
  output logic [N-1:0] rise,
  output logic [N-1:0] flag
);
  logic [N-1:0] prev;

  // ********************************
  // Edge capture
  // ********************************
  assign rise = lvl & ~prev;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev <= '0;
    end else begin
      prev <= lvl;
    end
  end

  // Set beats clear so an edge in the clearing cycle is kept
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag <= '0;
    end else begin
      flag <= rise | (flag & ~clr);
    end
  end

  property p_level_no_reset;
    @(posedge clk) disable iff (!rst_n)
    (|lvl) && $stable(lvl) && $past(rst_n) |-> rise == '0;
  endproperty
  a_level_no_reset: assert property (p_level_no_reset)
    else $error("Held level produced a new edge");

  property p_clear_works;
    @(posedge clk) disable iff (!rst_n)
    (clr[0] && !rise[0]) |=> !flag[0];
  endproperty
  a_clear_works: assert property (p_clear_works)
    else $error("Flag survived its clear");
endmodule // esft_sticky

// ### esft_core.sv
`timescale 1ns/1ps
module esft_core (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire esft_pkg::esft_func_t func_irq,
  input wire esft_pkg::esft_srcrd_t src_read,
  input wire logic [6:0] int_enable,
  input wire logic new_xyz_flag,
  input wire logic odr_clk,
  input wire logic active,
  input wire logic auto_sleep_en,
  input wire logic [7:0] inactivity_limit,
  input wire logic [3:0] wake_enable,
  input wire logic [1:0] fifo_mode,
  input wire logic [5:0] fifo_fill_count,
  input wire logic [5:0] fifo_watermark_level,
  input wire logic gate_error_detect,
  output logic fifo_trigger,
  output logic fifo_trigger_stop,
  output logic fifo_watermark_event,
  output logic sleep_rate_sel,
  output logic [1:0] operating_state
);
  logic [3:0] trig_en, trig_rise, trig_flag;
  logic [7:0] src_lvl, src_clr, src_flag, idle_cnt;
  logic odr_s1, odr_s2, odr_s3, odr_tick;
  esft_pkg::esft_state_t state, next_state;
  logic aslp_pulse, idle_out, operating_state_rd;
  logic fifo_gate_error, fifo_empty, trig_armed;
  logic [4:0] gate_error_age;
  logic [6:0] post_cnt, post_limit;

  function automatic logic rd_at(input logic [7:0] a, input logic [7:0] b,
                                 input logic rd);
    rd_at = rd && (a == b);
  endfunction

  // ********************************
  // Sample-rate tick, from a slow foreign clock
  // ********************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {odr_s3, odr_s2, odr_s1} <= 3'h0;
    end else begin
      {odr_s3, odr_s2, odr_s1} <= {odr_s2, odr_s1, odr_clk};
    end
  end
  assign odr_tick = odr_s2 & ~odr_s3;

  // ********************************
  // Trigger selection and FIFO trigger
  // ********************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trig_en <= esft_pkg::TRIG_RESET;
    end else if (reg_wr && reg_addr == esft_pkg::ADDR_TRIG) begin
      trig_en <= reg_wdata[esft_pkg::TRIG_LSB +: 4];
    end
  end

  esft_sticky #(.N(4)) u_trig (
    .clk(clk),
    .rst_n(rst_n),
    .lvl(func_irq),
    .clr({src_read.trans, src_read.orient, src_read.tap, src_read.fall}),
    .rise(trig_rise),
    .flag(trig_flag)
  );
  assign fifo_trigger = |(trig_rise & trig_en);

  // ********************************
  // Event source status
  // ********************************
  assign src_lvl = {aslp_pulse,
    int_enable[6] && (fifo_fill_count == esft_pkg::FIFO_FULL ||
      (fifo_watermark_level != esft_pkg::WMRK_OFF &&
       fifo_fill_count == fifo_watermark_level)),
    func_irq & int_enable[5:2], 1'b0,
    new_xyz_flag & int_enable[0]};
  assign src_clr = {operating_state_rd, src_read.fifo, src_read.trans,
    src_read.orient, src_read.tap, src_read.fall, 1'b0,
    ~new_xyz_flag};
  assign operating_state_rd = rd_at(reg_addr, esft_pkg::ADDR_OPERATING_STATE, reg_rd);
  esft_sticky #(.N(8)) u_src (
    .clk(clk),
    .rst_n(rst_n),
    .lvl(src_lvl),
    .clr(src_clr),
    .rise(),
    .flag(src_flag)
  );

  // ********************************
  // Operating state
  // ********************************
  assign idle_out = auto_sleep_en && odr_tick &&
    idle_cnt >= inactivity_limit;

  always_comb begin
    next_state = state;
    case (state)
      esft_pkg::ESFT_STANDBY: if (active) next_state = esft_pkg::ESFT_WAKE;
      esft_pkg::ESFT_WAKE: begin
        if (!active) next_state = esft_pkg::ESFT_STANDBY;
        else if (idle_out) next_state = esft_pkg::ESFT_SLEEP;
      end
      esft_pkg::ESFT_SLEEP: begin
        if (!active) next_state = esft_pkg::ESFT_STANDBY;
        else if (|(trig_rise & wake_enable) || !auto_sleep_en) begin
          next_state = esft_pkg::ESFT_WAKE;
        end
      end
      default: next_state = esft_pkg::ESFT_STANDBY;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= esft_pkg::ESFT_STANDBY;
    end else begin
      state <= next_state;
    end
  end

  // Any function interrupt edge restarts the idle count, so a busy sensor never sleeps
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idle_cnt <= 8'h00;
    end else if (state != esft_pkg::ESFT_WAKE || (|trig_rise)) begin
      idle_cnt <= 8'h00;
    end else if (odr_tick && idle_cnt != 8'hFF) begin
      idle_cnt <= idle_cnt + 8'h01;
    end
  end

  assign aslp_pulse = (state == esft_pkg::ESFT_WAKE &&
    next_state == esft_pkg::ESFT_SLEEP) ||
    (state == esft_pkg::ESFT_SLEEP && next_state == esft_pkg::ESFT_WAKE);

  always_comb begin
    case (state)
      esft_pkg::ESFT_WAKE: operating_state = esft_pkg::OPS_WAKE;
      esft_pkg::ESFT_SLEEP: operating_state = esft_pkg::OPS_SLEEP;
      default: operating_state = esft_pkg::OPS_STANDBY;
    endcase
  end
  assign sleep_rate_sel = (state == esft_pkg::ESFT_SLEEP);

  // ********************************
  // Gate error and its age
  // ********************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fifo_gate_error <= 1'b0;
    end else if (gate_error_detect || fifo_empty) begin
      fifo_gate_error <= gate_error_detect;
    end
  end
  assign fifo_empty = fifo_fill_count == esft_pkg::FIFO_EMPTY;
  // Saturates rather than wrapping, so a stale error never looks fresh
  always_ff @(posedge clk) begin
    if (!rst_n || !fifo_gate_error || (fifo_empty && !gate_error_detect)) begin
      gate_error_age <= 5'h00;
    end else if (odr_tick && gate_error_age != esft_pkg::AGE_MAX) begin
      gate_error_age <= gate_error_age + 5'h01;
    end
  end

  // ********************************
  // Trigger mode capture window and watermark
  // ********************************
  assign post_limit = esft_pkg::FIFO_DEPTH - {1'b0, fifo_watermark_level};

  always_ff @(posedge clk) begin
    if (!rst_n || fifo_mode != esft_pkg::FMODE_TRIGGER) begin
      trig_armed <= 1'b0;
    end else if (fifo_trigger) begin
      trig_armed <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || fifo_mode != esft_pkg::FMODE_TRIGGER) begin
      post_cnt <= 7'h00;
    end else if (trig_armed && odr_tick && post_cnt < post_limit) begin
      post_cnt <= post_cnt + 7'h01;
    end
  end
  assign fifo_trigger_stop = fifo_mode == esft_pkg::FMODE_TRIGGER &&
    trig_armed && post_cnt >= post_limit;
  assign fifo_watermark_event = fifo_watermark_level != esft_pkg::WMRK_OFF
    && fifo_fill_count >= fifo_watermark_level;

  // ********************************
  // Register reads
  // ********************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        esft_pkg::ADDR_TRIG: reg_rdata <= {2'h0, trig_en, 2'h0};
        esft_pkg::ADDR_OPERATING_STATE:
          reg_rdata <= {fifo_gate_error, gate_error_age, operating_state};
        esft_pkg::ADDR_INTSRC: reg_rdata <= src_flag;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ********************************
  // Checks
  // ********************************
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  property p_trig_reset;
    $rose(rst_n) |-> trig_en == 4'h0;
  endproperty
  a_trig_reset: assert property (p_trig_reset)
    else $error("Trigger enables not zero after reset");
  property p_disabled_no_trigger;
    (trig_en == 4'h0) |-> !fifo_trigger;
  endproperty
  a_disabled_no_trigger: assert property (p_disabled_no_trigger)
    else $error("Trigger fired with no source enabled");
  property p_trig_clear;
    src_read.trans && !trig_rise[3] |=> !trig_flag[3];
  endproperty
  a_trig_clear: assert property (p_trig_clear)
    else $error("Trigger indication survived its source read");
  property p_gate_clear;
    fifo_gate_error && fifo_fill_count == 6'h00 && !gate_error_detect
      |=> !fifo_gate_error ##0 gate_error_age == 5'h00;
  endproperty
  a_gate_clear: assert property (p_gate_clear)
    else $error("Gate error not cleared by empty FIFO");
  property p_age_zero;
    !fifo_gate_error |=> $past(fifo_gate_error) || gate_error_age == 5'h00;
  endproperty
  a_age_zero: assert property (p_age_zero)
    else $error("Age counter not zero without error");
  property p_drdy_follows;
    !new_xyz_flag |=> !src_flag[0];
  endproperty
  a_drdy_follows: assert property (p_drdy_follows)
    else $error("Data-ready bit held without new data");
  property p_aslp_clear;
    operating_state_rd && !aslp_pulse |=> !src_flag[7];
  endproperty
  a_aslp_clear: assert property (p_aslp_clear)
    else $error("Sleep/wake bit survived state read");
  property p_sleep_entry;
    state == esft_pkg::ESFT_WAKE && active && idle_out
      |=> operating_state == 2'h2 ##0 src_flag[7];
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("Idle timeout did not enter sleep");
  property p_wake_entry;
    state == esft_pkg::ESFT_SLEEP && active && |(trig_rise & wake_enable)
      |=> operating_state == 2'h1 ##0 !sleep_rate_sel;
  endproperty
  a_wake_entry: assert property (p_wake_entry)
    else $error("Wake event did not leave sleep");
  property p_stop_mode;
    fifo_trigger_stop |-> fifo_mode == 2'h3 && post_cnt == 7'h20 -
      {1'b0, fifo_watermark_level};
  endproperty
  a_stop_mode: assert property (p_stop_mode)
    else $error("Capture stop outside trigger window");
  property p_wmrk_off;
    fifo_watermark_level == 6'h00 |-> !fifo_watermark_event;
  endproperty
  a_wmrk_off: assert property (p_wmrk_off)
    else $error("Watermark event with zero watermark");
endmodule // esft_core

// ### esft_host.sv
`timescale 1ns/1ps
module esft_host (
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  output esft_pkg::esft_srcrd_t src_read
);
  // ****************************************
  // Host side of the register strobes
  // ****************************************
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    src_read = '0;
  end

  // Idle address and data show the inverse, so a stale value never matches
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // The state register is read to follow sleep and wake changes
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask

  task automatic src(input esft_pkg::esft_srcrd_t s);
    @(negedge clk);
    src_read = s;
    @(negedge clk);
    src_read = '0;
  endtask
endmodule // esft_host

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr, reg_rd, new_xyz_flag, active, auto_sleep_en;
  logic odr_clk, gate_error_detect, fifo_trigger, fifo_trigger_stop;
  logic fifo_watermark_event, sleep_rate_sel;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, inactivity_limit;
  logic [6:0] int_enable;
  logic [3:0] wake_enable;
  logic [1:0] fifo_mode, operating_state;
  logic [5:0] fifo_fill_count, fifo_watermark_level;
  esft_pkg::esft_func_t func_irq;
  esft_pkg::esft_srcrd_t src_read;
  int fail_count = 0;
  int total_checks = 0;

  always #10 clk = ~clk;

  esft_host i_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .src_read(src_read));

  esft_core i_dut (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .func_irq(func_irq), .src_read(src_read),
    .int_enable(int_enable), .new_xyz_flag(new_xyz_flag),
    .odr_clk(odr_clk), .active(active), .auto_sleep_en(auto_sleep_en),
    .inactivity_limit(inactivity_limit), .wake_enable(wake_enable),
    .fifo_mode(fifo_mode), .fifo_fill_count(fifo_fill_count),
    .fifo_watermark_level(fifo_watermark_level),
    .gate_error_detect(gate_error_detect), .fifo_trigger(fifo_trigger),
    .fifo_trigger_stop(fifo_trigger_stop),
    .fifo_watermark_event(fifo_watermark_event),
    .sleep_rate_sel(sleep_rate_sel), .operating_state(operating_state));

  // ****************************************
  // Checking and helpers
  // ****************************************
  task automatic test_done();
    if (fail_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_host.rd(a, d);
    chk("register read", d, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Link clock runs only while ticks are wanted, 160 ns a period
  task automatic tick(input int n);
    repeat (n) begin
      odr_clk = 1'b1;
      cyc(4);
      odr_clk = 1'b0;
      cyc(4);
    end
    cyc(4);
  endtask

  initial begin
    #100000;
    fail_count++;
    test_done();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    {new_xyz_flag, active, auto_sleep_en, odr_clk} = 4'h0;
    gate_error_detect = 1'b0;
    inactivity_limit = 8'h02;
    int_enable = 7'h7D;
    wake_enable = 4'hF;
    fifo_mode = 2'h0;
    fifo_fill_count = 6'h00;
    fifo_watermark_level = 6'h00;
    func_irq = '0;
    cyc(2);
    rst_n = 1'b1;
    rchk(esft_pkg::ADDR_TRIG, 8'h00);
    rchk(esft_pkg::ADDR_OPERATING_STATE, 8'h00);
    rchk(esft_pkg::ADDR_INTSRC, 8'h00);
    i_host.wr(esft_pkg::ADDR_TRIG, 8'hFF);
    rchk(esft_pkg::ADDR_TRIG, 8'h3C);
    i_host.wr(esft_pkg::ADDR_OPERATING_STATE, 8'hFF);
    rchk(esft_pkg::ADDR_OPERATING_STATE, 8'h00);
    rchk(8'h3F, 8'h00);
    for (int i = 0; i < 4; i++) begin
      i_host.wr(esft_pkg::ADDR_TRIG, 8'h04 << i);
      @(negedge clk);
      func_irq[i] = 1'b1;
      #1 chk("trigger", {7'h00, fifo_trigger}, 8'h01);
      @(negedge clk);
      chk("trigger", {7'h00, fifo_trigger}, 8'h00);
      chk("trigger flag", {4'h0, i_dut.trig_flag}, 8'h01 << i);
      rchk(esft_pkg::ADDR_INTSRC, 8'h04 << i);
      i_host.src(5'h01 << i);
      func_irq[i] = 1'b0;
      chk("trigger flag", {4'h0, i_dut.trig_flag}, 8'h00);
      rchk(esft_pkg::ADDR_INTSRC, 8'h00);
    end
    i_host.wr(esft_pkg::ADDR_TRIG, 8'h00);
    @(negedge clk);
    func_irq = 4'hF;
    #1 chk("trigger", {7'h00, fifo_trigger}, 8'h00);
    i_host.src(5'h0F);
    func_irq = 4'h0;
    i_host.src(5'h0F);
    new_xyz_flag = 1'b1;
    cyc(2);
    rchk(esft_pkg::ADDR_INTSRC, 8'h01);
    rchk(esft_pkg::ADDR_INTSRC, 8'h01);
    new_xyz_flag = 1'b0;
    cyc(2);
    rchk(esft_pkg::ADDR_INTSRC, 8'h00);
    fifo_watermark_level = 6'h04;
    fifo_fill_count = 6'h03;
    cyc(2);
    chk("watermark", {7'h00, fifo_watermark_event}, 8'h00);
    fifo_fill_count = 6'h04;
    cyc(2);
    rchk(esft_pkg::ADDR_INTSRC, 8'h40);
    i_host.src(5'h10);
    fifo_fill_count = 6'h05;
    cyc(2);
    chk("watermark", {7'h00, fifo_watermark_event}, 8'h01);
    rchk(esft_pkg::ADDR_INTSRC, 8'h00);
    fifo_watermark_level = 6'h00;
    cyc(1);
    chk("watermark", {7'h00, fifo_watermark_event}, 8'h00);
    fifo_fill_count = 6'h20;
    cyc(2);
    rchk(esft_pkg::ADDR_INTSRC, 8'h40);
    i_host.src(5'h10);
    fifo_fill_count = 6'h05;
    gate_error_detect = 1'b1;
    cyc(1);
    gate_error_detect = 1'b0;
    rchk(esft_pkg::ADDR_OPERATING_STATE, 8'h80);
    tick(3);
    rchk(esft_pkg::ADDR_OPERATING_STATE, 8'h8C);
    fifo_fill_count = 6'h00;
    cyc(2);
    rchk(esft_pkg::ADDR_OPERATING_STATE, 8'h00);
    active = 1'b1;
    auto_sleep_en = 1'b1;
    cyc(2);
    rchk(esft_pkg::ADDR_OPERATING_STATE, 8'h01);
    tick(4);
    chk("rate select", {7'h00, sleep_rate_sel}, 8'h01);
    rchk(esft_pkg::ADDR_INTSRC, 8'h80);
    rchk(esft_pkg::ADDR_OPERATING_STATE, 8'h02);
    rchk(esft_pkg::ADDR_INTSRC, 8'h00);
    func_irq[0] = 1'b1;
    cyc(2);
    chk("state", {6'h00, operating_state}, 8'h01);
    chk("rate select", {7'h00, sleep_rate_sel}, 8'h00);
    rchk(esft_pkg::ADDR_INTSRC, 8'h84);
    i_host.src(5'h01);
    func_irq[0] = 1'b0;
    rchk(esft_pkg::ADDR_OPERATING_STATE, 8'h01);
    auto_sleep_en = 1'b0;
    active = 1'b0;
    fifo_mode = esft_pkg::FMODE_TRIGGER;
    fifo_watermark_level = 6'h1C;
    i_host.wr(esft_pkg::ADDR_TRIG, 8'h20);
    func_irq[3] = 1'b1;
    cyc(2);
    chk("stop", {7'h00, fifo_trigger_stop}, 8'h00);
    tick(3);
    chk("stop", {7'h00, fifo_trigger_stop}, 8'h00);
    tick(1);
    chk("stop", {7'h00, fifo_trigger_stop}, 8'h01);
    fifo_mode = 2'h0;
    cyc(2);
    chk("stop", {7'h00, fifo_trigger_stop}, 8'h00);
    test_done();
  end
endmodule // tb_top
